// ---- dv/swuart_host.sv ----
// Host-side bus master model: sends datagrams and collects replies
`timescale 1ns/10ps
module swuart_host (
  input  wire logic i_clk,
  input  wire logic i_line,
  output logic      o_tx,
  output logic      o_oe
);
  int bt = 16;
  initial
  begin
    o_tx = 1'b1;
    o_oe = 1'b0;
  end
  function automatic logic [7:0] crc8(input logic [7:0] m [8], input int n);
    logic [7:0] c;
    logic [7:0] b;
    c = 8'h00;
    for (int i = 0; i < n; i++)
    begin
      b = m[i];
      for (int j = 0; j < 8; j++)
      begin
        c = (c[7] ^ b[0]) ? {c[6:0], 1'b0} ^ 8'h07 : {c[6:0], 1'b0};
        b = b >> 1;
      end
    end
    return c;
  endfunction
  // Eight data bits, no parity; the last byte carries the CRC, bad flips it
  task automatic send(input logic [7:0] m [8], input int n, input logic [7:0] bad);
    logic [9:0] f;
    m[n-1] = crc8(m, n - 1) ^ bad;
    @(posedge i_clk);
    o_oe <= 1'b1;
    for (int i = 0; i < n; i++)
    begin
      f = {1'b1, m[i], 1'b0};
      for (int k = 0; k < 10; k++)
      begin
        o_tx <= f[k];
        repeat (bt) @(posedge i_clk);
      end
    end
    o_oe <= 1'b0;
  endtask
  // Only called after our own bytes are out, so the echo is never taken as reply
  task automatic recv(output logic [7:0] m [8], output logic ok);
    int w;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      w = 0;
      while (i_line !== 1'b0 && w < 4000)
      begin
        @(posedge i_clk);
        w++;
      end
      if (w == 4000)
        ok = 1'b0;
      repeat (bt / 2) @(posedge i_clk);
      for (int k = 0; k < 9; k++)
      begin
        repeat (bt) @(posedge i_clk);
        if (k < 8)
          m[i][k] = i_line;
        else if (i_line !== 1'b1)
          ok = 1'b0;
      end
    end
  endtask
endmodule

// ---- dv/tb_top.sv ----
// Self-checking bench for the single-wire UART slave
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin bad_count++; \
  $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_top;
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        sel_lo = 1'b1;
  logic        sel_hi = 1'b0;
  logic [3:0]  dly = 4'h0;
  logic [31:0] rd_data = 32'h00000000;
  logic        wr_ready = 1'b0;
  logic        d_tx, d_oe, h_tx, h_oe, line, rd_req, wr_valid, oe_q;
  logic [6:0]  rd_addr, wr_addr, req_addr;
  logic [31:0] wr_data;
  logic [7:0]  cnt;
  int          bad_count = 0;
  int          check_count = 0;
  int          cyc = 0, req_n = 0, req_t = 0, up_n = 0, up_t = 0, dn_t = 0;
  always #2 mclk = ~mclk;
  // Pull-up holds the wire high whenever neither side drives
  assign line = (d_oe === 1'b1) ? d_tx : (h_oe === 1'b1) ? h_tx : 1'b1;
  swuart_slave #(.BIT_W(16)) dut (
    .I_MCLK(mclk), .I_RST_N(rst_n), .I_SERIAL_LINE_PIN(line), .O_SERIAL_LINE_PIN(d_tx),
    .O_SERIAL_LINE_OE(d_oe), .I_ADDR_SELECT_LOW_PIN(sel_lo), .I_ADDR_SELECT_HIGH_PIN(sel_hi),
    .I_REPLY_TURNAROUND_DELAY(dly), .O_RD_REQ(rd_req), .O_RD_ADDR(rd_addr),
    .I_RD_DATA(rd_data), .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready), .O_WR_ADDR(wr_addr),
    .O_WR_DATA(wr_data), .O_DGRAM_CNT(cnt));
  swuart_host host (.i_clk(mclk), .i_line(line), .o_tx(h_tx), .o_oe(h_oe));
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    oe_q <= d_oe;
    if (rd_req === 1'b1)
    begin
      req_n <= req_n + 1;
      req_t <= cyc;
      req_addr <= rd_addr;
    end
    if (d_oe === 1'b1 && oe_q === 1'b0)
    begin
      up_n <= up_n + 1;
      up_t <= cyc;
    end
    if (d_oe === 1'b0 && oe_q === 1'b1)
      dn_t <= cyc;
  end
  task automatic t_read(input logic [1:0] node, input logic [3:0] d, input logic [6:0] rg,
                        input logic [31:0] v);
    logic [7:0] m [8];
    logic [7:0] r [8];
    logic       ok;
    logic [7:0] c0;
    int         n0, s, b;
    n0 = req_n;
    c0 = cnt;
    b = host.bt;
    s = 8 * ((d == 4'h0) ? 1 : int'(d)) * b;
    @(posedge mclk);
    sel_lo <= node[0];
    sel_hi <= node[1];
    dly <= d;
    rd_data <= v;
    repeat (4) @(posedge mclk);
    m = '{8'h05, {6'h00, node}, {1'b0, rg}, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    host.send(m, 4, 8'h00);
    host.recv(r, ok);
    repeat (6 * b) @(posedge mclk);
    m = '{8'h05, 8'hff, {1'b0, rg}, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    m[7] = host.crc8(m, 7);
    `CHK("request pulse", n0 + 1, req_n)
    `CHK("request reg", rg, req_addr)
    `CHK("reply framing", 1'b1, ok)
    for (int i = 0; i < 8; i++)
      `CHK("reply byte", m[i], r[i])
    `CHK("turnaround", 1'b1, (up_t - req_t) inside {[s - 2 : s + 2]})
    `CHK("release", 1'b1, (dn_t - up_t) inside {[84 * b - 2 : 84 * b + 2]})
    `CHK("count kept", c0, cnt)
    $display("read test done");
  endtask
  // Idle gap after each datagram also covers the recovery after a bad one
  task automatic t_write(input logic [7:0] a, input logic [6:0] rg, input logic [31:0] v,
                         input logic [7:0] bad);
    logic [7:0] m [8];
    m = '{8'h05, a, {1'b1, rg}, v[31:24], v[23:16], v[15:8], v[7:0], 8'h00};
    host.send(m, 8, bad);
    repeat (14 * host.bt) @(posedge mclk);
  endtask
  task automatic t_fifo();
    logic [7:0] c0;
    int         u0;
    c0 = cnt;
    u0 = up_n;
    for (int i = 0; i < 16; i++)
      t_write(8'h01, 7'h20 + i[6:0], 32'hc0de0000 + i, 8'h00);
    `CHK("write count", c0 + 8'd16, cnt)
    `CHK("no drive on write", u0, up_n)
    wr_ready <= 1'b1;
    for (int i = 0; i < 16; i++)
    begin
      @(negedge mclk);
      `CHK("queue valid", 1'b1, wr_valid)
      `CHK("queue addr", 7'h20 + i[6:0], wr_addr)
      `CHK("queue data", 32'hc0de0000 + i, wr_data)
      @(posedge mclk);
    end
    wr_ready <= 1'b0;
    @(negedge mclk);
    `CHK("queue empty", 1'b0, wr_valid)
    $display("queue test done");
  endtask
  task automatic t_ignore();
    logic [7:0] m [8];
    logic [7:0] c0;
    int         n0, u0;
    c0 = cnt;
    n0 = req_n;
    u0 = up_n;
    t_write(8'h01, 7'h11, 32'h12345678, 8'h5a);
    t_write(8'h03, 7'h11, 32'h12345678, 8'h00);
    t_write(8'hff, 7'h11, 32'h12345678, 8'h00);
    `CHK("ignored count", c0, cnt)
    `CHK("ignored queue", 1'b0, wr_valid)
    `CHK("ignored drive", u0, up_n)
    t_write(8'h01, 7'h11, 32'h12345678, 8'h00);
    `CHK("recovered count", c0 + 8'd1, cnt)
    // Cut datagram: only the gap limit lets the following write be taken whole
    m = '{8'h05, 8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    host.send(m, 3, 8'h00);
    repeat (80 * host.bt) @(posedge mclk);
    t_write(8'h01, 7'h11, 32'h12345678, 8'h00);
    `CHK("gap recovered count", c0 + 8'd2, cnt)
    wr_ready <= 1'b1;
    repeat (2) @(posedge mclk);
    wr_ready <= 1'b0;
    $display("ignore test done");
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    // Tests take about 40000 cycles; the rest is margin
    repeat (60000) @(posedge mclk);
    bad_count++;
    final_report();
  end
  initial
  begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK("reset drive", 1'b0, d_oe)
    `CHK("reset count", 8'h00, cnt)
    t_read(2'b01, 4'h0, 7'h12, 32'ha1b2c3d4);
    t_fifo();
    t_ignore();
    host.bt = 24;
    t_read(2'b10, 4'h2, 7'h05, 32'h00ff5aa5);
    final_report();
  end
endmodule

// ---- hw/swuart_pkg.sv ----
// Constants for the single-wire UART slave with read replies and CRC
// Overview of operation
// - Read request is 4 bytes: sync, slave address, read flag plus register, CRC.
// - Reply goes out at the baud rate measured from the request.
// - Reply waits a turnaround of eight-bit-time steps, default eight bit times.
// - Reply is 8 bytes: sync, address 0xff, register, 32 data bits, CRC.
// - Reply data goes most significant byte first.
// - Address 0xff is reserved for replies; no node owns it.
// - Driver is released four bit times after the reply's last stop bit.
// - CRC8 x^8+x^2+x+1, zero seed, over all prior bytes, LSB first.
// - Sync nibble is taken as correct when checking the CRC.
// - Only datagrams with good CRC and own address are acted on.
// - Datagram counter counts accepted writes only and wraps at 8 bits.
// - One non-inverted two-way pin carries both receive and transmit.
// - Node address low bit from first select pin, high bit from second.
// - Line is watched except while a reply is pending, being sent or in its four release bit times, or a write waits for room in a full queue.
// - Bit time is remeasured from each sync nibble.
// - Driver is enabled only while a read reply is being sent and for the four release bit times after it.
// - Bytes have low start and high stop; bit time is a quarter of start to second sync fall.
// - Register byte top bit: zero is read, one is write.
// - Over 63 bit times between byte starts resets reception; 12 idle recover.
// - Line rests high when nobody transmits.
package swuart_pkg;
  localparam logic [3:0] SYNC_NIBBLE          = 4'h5;
  localparam logic [3:0] SYNC_RESERVED        = 4'h0;
  localparam logic [7:0] MASTER_ADDR          = 8'hff;
  localparam logic [7:0] CRC_POLY             = 8'h07;
  localparam logic [7:0] CRC_SEED             = 8'h00;
  localparam int         ADDR_BYTE            = 1;
  localparam int         REG_BYTE             = 2;
  localparam int         RW_FLAG_BIT          = 7;
  localparam int         SHORT_LAST_BYTE      = 3;
  localparam int         LONG_LAST_BYTE       = 7;
  localparam int         STOP_BIT_IDX         = 8;
  localparam int         FRAME_LAST_BIT       = 9;
  localparam int         GAP_BIT_TIMES        = 63;
  localparam int         RECOVER_BIT_TIMES    = 12;
  localparam int         RELEASE_BIT_TIMES    = 4;
  localparam int         DELAY_STEP_BIT_TIMES = 8;
  localparam logic [3:0] DELAY_STEPS_DEFAULT  = 4'h1;
  localparam int         GLITCH_CYCLES        = 16;
  localparam int         FIFO_DEPTH           = 16;
  localparam logic       LINE_IDLE            = 1'b1;
endpackage

// ---- hw/swuart_slave.sv ----
// Single-wire UART slave: request receiver, reply sender and write queue
`timescale 1ns/10ps
module swuart_fifo #(
  parameter int WIDTH = 39,
  parameter int DEPTH = swuart_pkg::FIFO_DEPTH
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  // Pointers wrap naturally, so DEPTH must be a power of two
  localparam int          AW   = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;
  wire              push;
  wire              pop;

  assign o_in_ready  = (fill != FULL);
  assign o_out_valid = (fill != '0);
  assign o_out_data  = mem[rd_ptr];
  assign push        = i_in_valid && o_in_ready;
  assign pop         = o_out_valid && i_out_ready;

  always_ff @(posedge i_clk)
  begin
    if (!i_rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + AW'(push);
      rd_ptr <= rd_ptr + AW'(pop);
      fill   <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (push)
      mem[wr_ptr] <= i_in_data;
  end
endmodule

module swuart_slave #(
  parameter int BIT_W = 16
) (
  input  wire logic        I_MCLK,
  input  wire logic        I_RST_N,
  input  wire logic        I_SERIAL_LINE_PIN,
  output logic             O_SERIAL_LINE_PIN,
  output logic             O_SERIAL_LINE_OE,
  input  wire logic        I_ADDR_SELECT_LOW_PIN,
  input  wire logic        I_ADDR_SELECT_HIGH_PIN,
  input  wire logic [3:0]  I_REPLY_TURNAROUND_DELAY,
  output logic             O_RD_REQ,
  output logic      [6:0]  O_RD_ADDR,
  input  wire logic [31:0] I_RD_DATA,
  output logic             O_WR_VALID,
  input  wire logic        I_WR_READY,
  output logic      [6:0]  O_WR_ADDR,
  output logic      [31:0] O_WR_DATA,
  output logic      [7:0]  O_DGRAM_CNT
);
  localparam int CNT_W = BIT_W + 6;

  typedef enum logic [2:0] {R_IDLE, R_SYNC, R_BITS, R_GAP, R_PUSH, R_RECOVER} rx_state_t;
  typedef enum logic [1:0] {T_IDLE, T_DELAY, T_SEND, T_RELEASE} tx_state_t;

  rx_state_t        rx_state;
  rx_state_t        next_rx_state;
  logic [CNT_W-1:0] rx_tmr;
  logic [CNT_W-1:0] next_rx_tmr;
  logic [CNT_W-1:0] gap_tmr;
  logic [CNT_W-1:0] next_gap_tmr;
  logic [BIT_W-1:0] bit_time;
  logic [BIT_W-1:0] next_bit_time;
  logic             edge_seen;
  logic             next_edge_seen;
  logic [3:0]       bit_idx;
  logic [3:0]       next_bit_idx;
  logic [7:0]       shreg;
  logic [7:0]       next_shreg;
  logic [2:0]       byte_idx;
  logic [2:0]       next_byte_idx;
  logic [63:0]      dgram;
  logic [63:0]      next_dgram;
  logic [7:0]       rx_crc;
  logic [7:0]       next_rx_crc;
  logic             line_prev;
  logic [1:0]       node_address;
  logic [7:0]       dgram_cnt;

  tx_state_t        tx_state;
  tx_state_t        next_tx_state;
  logic [BIT_W-1:0] tx_bit_time;
  logic [BIT_W-1:0] next_tx_bit_time;
  logic [BIT_W-1:0] tx_tmr;
  logic [BIT_W-1:0] next_tx_tmr;
  logic [6:0]       tx_cnt;
  logic [6:0]       next_tx_cnt;
  logic [2:0]       tx_byte_idx;
  logic [2:0]       next_tx_byte_idx;
  logic [63:0]      tx_frame;
  logic [63:0]      next_tx_frame;
  logic [7:0]       tx_crc;
  logic [7:0]       next_tx_crc;
  logic [9:0]       tx_shift;
  logic [9:0]       next_tx_shift;
  logic             tx_oe;
  logic             next_tx_oe;

  function automatic logic [7:0] crc_byte(input logic [7:0] crc, input logic [7:0] data);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++)
    begin
      if (c[7] ^ data[i])
        c = {c[6:0], 1'b0} ^ swuart_pkg::CRC_POLY;
      else
        c = {c[6:0], 1'b0};
    end
    return c;
  endfunction

  // Receive decode
  wire             line_in   = I_SERIAL_LINE_PIN;
  wire             rx_fall   = line_prev && !line_in;
  wire             tx_idle   = (tx_state == T_IDLE);
  wire [CNT_W-1:0] bit_lim   = CNT_W'(bit_time) - 1'b1;
  wire [CNT_W-1:0] half_bit  = CNT_W'(bit_time[BIT_W-1:1]);
  wire [CNT_W-1:0] gap_limit = CNT_W'(bit_time) * CNT_W'(swuart_pkg::GAP_BIT_TIMES);
  wire [CNT_W-1:0] rec_limit = CNT_W'(bit_time) * CNT_W'(swuart_pkg::RECOVER_BIT_TIMES);
  wire             stop_slot = (rx_state == R_BITS) && (rx_tmr == '0)
                               && (bit_idx == 4'(swuart_pkg::STOP_BIT_IDX));
  wire             byte_done = stop_slot && line_in;
  // The received nibble is replaced by the known pattern before the CRC
  wire [7:0]       rx_byte   = (byte_idx == '0) ? {shreg[7:4], swuart_pkg::SYNC_NIBBLE}
                                                : shreg;
  wire             rw_write  = dgram[8*swuart_pkg::REG_BYTE + swuart_pkg::RW_FLAG_BIT];
  wire             last_rd   = (byte_idx == 3'(swuart_pkg::SHORT_LAST_BYTE)) && !rw_write;
  wire             last_wr   = (byte_idx == 3'(swuart_pkg::LONG_LAST_BYTE));
  wire             crc_ok    = (rx_crc == rx_byte);
  // Node address never reaches 0xff, so reply echoes are never taken
  wire             addr_ok   = (dgram[8*swuart_pkg::ADDR_BYTE +: 8] == {6'h00, node_address});
  wire             rd_accept = byte_done && last_rd && crc_ok && addr_ok;
  wire             fifo_ready;
  wire             push_fire = (rx_state == R_PUSH) && fifo_ready;

  always_comb
  begin
    next_rx_state  = rx_state;
    next_rx_tmr    = rx_tmr;
    next_gap_tmr   = gap_tmr + 1'b1;
    next_bit_time  = bit_time;
    next_edge_seen = edge_seen;
    next_bit_idx   = bit_idx;
    next_shreg     = shreg;
    next_byte_idx  = byte_idx;
    next_dgram     = dgram;
    next_rx_crc    = rx_crc;
    unique case (rx_state)
      R_IDLE:
      begin
        next_gap_tmr = '0;
        // Own echo is ignored while the reply is pending or on the line
        if (rx_fall && tx_idle)
        begin
          next_rx_state  = R_SYNC;
          next_rx_tmr    = CNT_W'(1);
          next_edge_seen = 1'b0;
        end
      end
      R_SYNC:
      begin
        next_rx_tmr = rx_tmr + 1'b1;
        if ((line_in && rx_tmr < CNT_W'(swuart_pkg::GLITCH_CYCLES)) || (&rx_tmr))
        begin
          next_rx_state = R_RECOVER;
          next_rx_tmr   = '0;
        end
        else if (rx_fall && edge_seen)
        begin
          next_bit_time = rx_tmr[BIT_W+1:2];
          next_rx_tmr   = rx_tmr >> 3;
          next_bit_idx  = 4'd3;
          next_byte_idx = '0;
          next_rx_crc   = swuart_pkg::CRC_SEED;
          next_rx_state = R_BITS;
        end
        else if (rx_fall)
          next_edge_seen = 1'b1;
      end
      R_BITS:
      begin
        if (rx_tmr != '0)
          next_rx_tmr = rx_tmr - 1'b1;
        else if (!stop_slot)
        begin
          next_shreg   = {line_in, shreg[7:1]};
          next_bit_idx = bit_idx + 1'b1;
          next_rx_tmr  = bit_lim;
        end
        else if (!line_in)
        begin
          next_rx_state = R_RECOVER;
          next_rx_tmr   = '0;
        end
        else
        begin
          next_dgram[{byte_idx, 3'b000} +: 8] = rx_byte;
          next_rx_crc   = crc_byte(rx_crc, rx_byte);
          next_byte_idx = byte_idx + 1'b1;
          next_rx_state = R_GAP;
          if (last_rd || last_wr)
          begin
            next_rx_tmr = '0;
            if (!crc_ok)
              next_rx_state = R_RECOVER;
            else if (addr_ok && last_wr)
              next_rx_state = R_PUSH;
            else
              next_rx_state = R_IDLE;
          end
        end
      end
      R_GAP:
      begin
        if (gap_tmr > gap_limit)
        begin
          next_rx_state = R_RECOVER;
          next_rx_tmr   = '0;
        end
        else if (rx_fall)
        begin
          next_gap_tmr  = '0;
          next_rx_tmr   = CNT_W'(bit_time) + half_bit;
          next_bit_idx  = '0;
          next_rx_state = R_BITS;
        end
      end
      R_PUSH:
      begin
        // Bytes that arrive while the queue is full are lost
        if (fifo_ready)
          next_rx_state = R_IDLE;
      end
      R_RECOVER:
      begin
        if (!line_in)
          next_rx_tmr = '0;
        else if (rx_tmr >= rec_limit)
          next_rx_state = R_IDLE;
        else
          next_rx_tmr = rx_tmr + 1'b1;
      end
      default:
        next_rx_state = R_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      rx_state     <= R_IDLE;
      rx_tmr       <= '0;
      gap_tmr      <= '0;
      bit_time     <= '1;
      edge_seen    <= 1'b0;
      bit_idx      <= '0;
      shreg        <= '0;
      byte_idx     <= '0;
      dgram        <= '0;
      rx_crc       <= swuart_pkg::CRC_SEED;
      line_prev    <= swuart_pkg::LINE_IDLE;
      node_address <= '0;
      dgram_cnt    <= '0;
    end
    else
    begin
      rx_state     <= next_rx_state;
      rx_tmr       <= next_rx_tmr;
      gap_tmr      <= next_gap_tmr;
      bit_time     <= next_bit_time;
      edge_seen    <= next_edge_seen;
      bit_idx      <= next_bit_idx;
      shreg        <= next_shreg;
      byte_idx     <= next_byte_idx;
      dgram        <= next_dgram;
      rx_crc       <= next_rx_crc;
      line_prev    <= line_in;
      node_address <= {I_ADDR_SELECT_HIGH_PIN, I_ADDR_SELECT_LOW_PIN};
      dgram_cnt    <= dgram_cnt + 8'(push_fire);
    end
  end

  // Reply sender
  wire [3:0]  delay_steps = (I_REPLY_TURNAROUND_DELAY == '0) ? swuart_pkg::DELAY_STEPS_DEFAULT
                                                           : I_REPLY_TURNAROUND_DELAY;
  wire [6:0]  delay_last  = 7'(delay_steps) * 7'(swuart_pkg::DELAY_STEP_BIT_TIMES) - 7'd1;
  wire        tx_tick     = (tx_tmr == '0);
  wire        byte_end    = tx_tick && (tx_cnt == 7'(swuart_pkg::FRAME_LAST_BIT));
  wire [7:0]  tx_nbyte    = (tx_byte_idx == 3'(swuart_pkg::LONG_LAST_BYTE - 1)) ? tx_crc
                            : tx_frame[{tx_byte_idx + 3'd1, 3'b000} +: 8];
  wire [63:0] reply_frame = {8'h00, I_RD_DATA[7:0], I_RD_DATA[15:8], I_RD_DATA[23:16],
                             I_RD_DATA[31:24], dgram[8*swuart_pkg::REG_BYTE +: 8],
                             swuart_pkg::MASTER_ADDR, swuart_pkg::SYNC_RESERVED,
                             swuart_pkg::SYNC_NIBBLE};

  always_comb
  begin
    next_tx_state    = tx_state;
    next_tx_bit_time = tx_bit_time;
    next_tx_tmr      = tx_tick ? tx_bit_time - 1'b1 : tx_tmr - 1'b1;
    next_tx_cnt      = tx_tick ? tx_cnt + 1'b1 : tx_cnt;
    next_tx_byte_idx = tx_byte_idx;
    next_tx_frame    = tx_frame;
    next_tx_crc      = tx_crc;
    next_tx_shift    = tx_shift;
    next_tx_oe       = tx_oe;
    unique case (tx_state)
      T_IDLE:
      begin
        next_tx_tmr = '0;
        next_tx_cnt = '0;
        if (rd_accept)
        begin
          next_tx_state    = T_DELAY;
          next_tx_bit_time = bit_time;
          next_tx_tmr      = bit_time - 1'b1;
          next_tx_frame    = reply_frame;
        end
      end
      T_DELAY:
      begin
        if (tx_tick && tx_cnt == delay_last)
        begin
          next_tx_state    = T_SEND;
          next_tx_cnt      = '0;
          next_tx_byte_idx = '0;
          next_tx_shift    = {1'b1, tx_frame[7:0], 1'b0};
          next_tx_crc      = crc_byte(swuart_pkg::CRC_SEED, tx_frame[7:0]);
          next_tx_oe       = 1'b1;
        end
      end
      T_SEND:
      begin
        if (tx_tick)
          next_tx_shift = {1'b1, tx_shift[9:1]};
        if (byte_end)
        begin
          next_tx_cnt = '0;
          if (tx_byte_idx == 3'(swuart_pkg::LONG_LAST_BYTE))
            next_tx_state = T_RELEASE;
          else
          begin
            next_tx_byte_idx = tx_byte_idx + 1'b1;
            next_tx_shift    = {1'b1, tx_nbyte, 1'b0};
            next_tx_crc      = crc_byte(tx_crc, tx_nbyte);
          end
        end
      end
      T_RELEASE:
      begin
        // Line is held high until the driver lets go
        if (tx_tick && tx_cnt == 7'(swuart_pkg::RELEASE_BIT_TIMES - 1))
        begin
          next_tx_state = T_IDLE;
          next_tx_oe    = 1'b0;
        end
      end
    endcase
  end

  always_ff @(posedge I_MCLK)
  begin
    if (!I_RST_N)
    begin
      tx_state    <= T_IDLE;
      tx_bit_time <= '1;
      tx_tmr      <= '0;
      tx_cnt      <= '0;
      tx_byte_idx <= '0;
      tx_frame    <= '0;
      tx_crc      <= swuart_pkg::CRC_SEED;
      tx_shift    <= '1;
      tx_oe       <= 1'b0;
    end
    else
    begin
      tx_state    <= next_tx_state;
      tx_bit_time <= next_tx_bit_time;
      tx_tmr      <= next_tx_tmr;
      tx_cnt      <= next_tx_cnt;
      tx_byte_idx <= next_tx_byte_idx;
      tx_frame    <= next_tx_frame;
      tx_crc      <= next_tx_crc;
      tx_shift    <= next_tx_shift;
      tx_oe       <= next_tx_oe;
    end
  end

  assign O_SERIAL_LINE_PIN = tx_shift[0];
  assign O_SERIAL_LINE_OE  = tx_oe;
  assign O_RD_REQ          = rd_accept;
  assign O_RD_ADDR         = dgram[8*swuart_pkg::REG_BYTE +: 7];
  assign O_DGRAM_CNT       = dgram_cnt;

  swuart_fifo #(
    .WIDTH (39),
    .DEPTH (swuart_pkg::FIFO_DEPTH)
  ) u_wr_fifo (
    .i_clk       (I_MCLK),
    .i_rst_n     (I_RST_N),
    .i_in_valid  (rx_state == R_PUSH),
    .o_in_ready  (fifo_ready),
    .i_in_data   ({dgram[22:16], dgram[31:24], dgram[39:32], dgram[47:40], dgram[55:48]}),
    .o_out_valid (O_WR_VALID),
    .i_out_ready (I_WR_READY),
    .o_out_data  ({O_WR_ADDR, O_WR_DATA})
  );

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);

  property p_rd_match;
    rd_accept |-> addr_ok && crc_ok && !rw_write && byte_idx == 3'd3;
  endproperty
  a_rd_match: assert property (p_rd_match) else $error("read taken without match");
  property p_cnt_read;
    rd_accept |=> ##1 $stable(O_DGRAM_CNT);
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("read changed counter");
  property p_cnt_write;
    $changed(O_DGRAM_CNT) |-> $past(push_fire) && O_DGRAM_CNT == $past(O_DGRAM_CNT) + 8'd1;
  endproperty
  a_cnt_write: assert property (p_cnt_write) else $error("counter step wrong");
  property p_baud;
    rd_accept |=> tx_bit_time == $past(bit_time);
  endproperty
  a_baud: assert property (p_baud) else $error("reply baud differs");
  property p_layout;
    rd_accept |=> tx_frame[15:8] == 8'hff && tx_frame[7:0] == 8'h05
                  && tx_frame[31:24] == $past(I_RD_DATA[31:24])
                  && tx_frame[55:48] == $past(I_RD_DATA[7:0]);
  endproperty
  a_layout: assert property (p_layout) else $error("reply frame wrong");
  property p_quiet;
    rd_accept |=> (!O_SERIAL_LINE_OE && tx_state == T_DELAY) [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("reply started early");
  property p_release;
    $fell(O_SERIAL_LINE_OE) |-> $past(tx_state) == T_RELEASE && $past(tx_cnt) == 7'd3;
  endproperty
  a_release: assert property (p_release) else $error("driver release timing");
  property p_idle_high;
    !O_SERIAL_LINE_OE |-> O_SERIAL_LINE_PIN;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("undriven level low");
  property p_no_write_tx;
    rx_state == R_PUSH |-> !O_SERIAL_LINE_OE && tx_state == T_IDLE;
  endproperty
  a_no_write_tx: assert property (p_no_write_tx) else $error("write drove line");
  property p_node;
    $past(I_RST_N) |-> node_address == $past({I_ADDR_SELECT_HIGH_PIN, I_ADDR_SELECT_LOW_PIN});
  endproperty
  a_node: assert property (p_node) else $error("node address mismatch");
endmodule
